// ===== src/ssw_pkg.sv
// How it works
// [R01] Both positioning-done flags follow completion
// [R02] Torque-clamped flag follows torque limiting
// [R03] Zero-speed flag follows zero-speed detection
// [R04] Speed-match flag follows speed coincidence
// [R05] Each warning output follows its selection
// [R06] Selector zero gives OR of warnings
// [R07] Selectors one to ten pick one warning
// [R08] Software writes only codes zero to ten
// [R09] Warnings hold one to ten seconds, or forever
// [R10] Battery and lifetime warnings never time out
// [R11] Mask bit one suppresses that warning
// [R12] Mask bit positions per warning source
// [R13] Load factors at 85 percent raise warnings
// [R14] Fan stopped one second raises warning
// [R15] Too many consecutive link errors raise warning
// [R16] Energy-saving fan stop raises no warning
// [R17] Position-command flag while command applied
// [R18] Speed-limited flag while torque control limits
// [R19] Clearable-alarm flag for clearable alarms
// [R20] Speed-command flag under speed control only
// [R21] Battery and lifetime routable as codes 3, 8
// [R22] Speed-arrival flag at or above threshold
// [R23] Per-source latching, outputs from latched vector
package ssw_pkg;

    // =========================================
    // Warning indices (selector code minus one)
    localparam int NUM_WARN = 10;
    localparam int W_OVERLOAD = 0;
    localparam int W_REGEN = 1;
    localparam int W_BATTERY = 2;
    localparam int W_FAN = 3;
    localparam int W_ENC_COMM = 4;
    localparam int W_ENC_HEAT = 5;
    localparam int W_OSC = 6;
    localparam int W_LIFE = 7;
    localparam int W_SCL_ERR = 8;
    localparam int W_SCL_COMM = 9;

    // =========================================
    // Selector codes
    localparam logic [3:0] SEL_ALL = 4'h0;
    localparam logic [3:0] SEL_MAX = 4'ha;

    // Mask bit position of each warning, index 0 rightmost
    localparam logic [9:0][3:0] MASK_POS = {4'ha, 4'h8, 4'h2, 4'h9, 4'h3,
                                            4'h4, 4'h6, 4'h0, 4'h5, 4'h7};

    // =========================================
    // Thresholds, times and reset values
    localparam logic [7:0] LOAD_WARN_PCT = 8'h55;
    localparam logic [3:0] HOLD_NO_LIMIT = 4'h0;
    localparam logic [3:0] HOLD_MAX_SEC = 4'ha;
    localparam longint CLK_HZ = 20_000_000;
    localparam longint SEC_MS = 1000;
    localparam longint FAN_STOP_MS = 1000;
    localparam longint SEC_CYC = CLK_HZ * SEC_MS / 1000;
    localparam longint FAN_STOP_CYC = CLK_HZ * FAN_STOP_MS / 1000;
    localparam logic [31:0] CNT_RST = 32'h0;
    localparam logic [7:0] ERR_RST = 8'h0;

    // =========================================
    // Carriers
    typedef struct packed {
        logic positioning_complete;
        logic positioning_complete_second;
        logic torque_at_limit;
        logic speed_is_zero;
        logic speed_coincident;
        logic [15:0] motor_speed;
        logic [15:0] arrival_speed;
        logic position_cmd_active;
        logic speed_limit_active;
        logic alarm_clearable;
        logic speed_cmd_active;
        logic speed_control_mode;
    } ssw_motion_t;

    typedef struct packed {
        logic [7:0] load_factor;
        logic [7:0] regen_factor;
        logic battery_low;
        logic fan_stopped;
        logic fan_saving_stop;
        logic enc_comm_err;
        logic enc_comm_ok;
        logic [7:0] enc_err_limit;
        logic enc_overheat;
        logic oscillation;
        logic life_short;
        logic scale_alarm;
        logic scale_comm_err;
        logic scale_comm_ok;
        logic [7:0] scale_err_limit;
    } ssw_warn_in_t;

    typedef struct packed {
        logic positioning_done;
        logic positioning_done_second;
        logic torque_clamped_flag;
        logic zero_speed_flag;
        logic speed_match_flag;
        logic speed_arrival_flag;
        logic position_cmd_flag;
        logic speed_limited_flag;
        logic clearable_alarm_flag;
        logic speed_cmd_flag;
    } ssw_flags_t;

    typedef struct packed {
        ssw_flags_t flags;
        logic [9:0] latch;
        logic [9:0][3:0] hold;
        logic [31:0] sec_cnt;
        logic tick;
        logic [31:0] fan_cnt;
        logic [7:0] enc_err;
        logic [7:0] scl_err;
    } ssw_state_t;

endpackage

// ===== src/ssw_status.sv
`timescale 1ns/1ps
module ssw_status #(
    parameter longint SEC_CYCLES = ssw_pkg::SEC_CYC,
    parameter longint FAN_CYCLES = ssw_pkg::FAN_STOP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire ssw_pkg::ssw_motion_t motion,
    input wire ssw_pkg::ssw_warn_in_t warn_in,
    input wire logic [3:0] warning_select_a,
    input wire logic [3:0] warning_select_b,
    input wire logic [3:0] warning_hold_time,
    input wire logic [10:0] warning_mask,
    input wire logic warning_clear,
    output ssw_pkg::ssw_flags_t flags,
    output logic [9:0] warning_latched,
    output logic warning_out_a,
    output logic warning_out_b,
    output logic status_output_five,
    output logic status_output_six
);
    import ssw_pkg::*;

    // =========================================
    // Elaboration checks
    generate
        if (SEC_CYCLES < 1 || SEC_CYCLES > 64'hffff_ffff)
        begin : g_bad_sec
            $error("Second prescaler count out of range");
        end
        if (FAN_CYCLES < 1 || FAN_CYCLES > 64'hffff_fffe)
        begin : g_bad_fan
            $error("Fan stop count out of range");
        end
    endgenerate

    localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
    localparam logic [31:0] FAN_LIMIT = 32'(FAN_CYCLES);

    // =========================================
    // Selector decode, shared by both outputs
    function automatic logic route_warn(input logic [3:0] sel, input logic [9:0] vec);
        logic r;
        r = 1'b0;
        // [R06] Code zero gives OR of all
        if (sel == SEL_ALL)
        begin
            r = |vec;
        end
        // [R07] [R21] Codes one to ten pick one warning
        else if (sel <= SEL_MAX)
        begin
            r = vec[sel - 4'h1];
        end
        return r;
    endfunction

    // =========================================
    // State
    ssw_state_t state_q; // Registered state
    ssw_state_t state_d; // Next state
    logic [9:0] raw; // Unmasked raw detections
    logic [9:0] masked; // Mask bit per warning
    logic [9:0] det; // Enabled detections
    logic [9:0] no_limit; // Warnings that never time out

    // =========================================
    // Raw warning detection
    always_comb
    begin
        raw = '0;
        // [R13] Load factor thresholds
        raw[W_OVERLOAD] = warn_in.load_factor >= LOAD_WARN_PCT;
        raw[W_REGEN] = warn_in.regen_factor >= LOAD_WARN_PCT;
        raw[W_BATTERY] = warn_in.battery_low;
        // [R14] Fan stopped one second
        raw[W_FAN] = state_q.fan_cnt >= FAN_LIMIT;
        // [R15] Consecutive error limits
        raw[W_ENC_COMM] = state_q.enc_err > warn_in.enc_err_limit;
        raw[W_SCL_COMM] = state_q.scl_err > warn_in.scale_err_limit;
        raw[W_ENC_HEAT] = warn_in.enc_overheat;
        raw[W_OSC] = warn_in.oscillation;
        raw[W_LIFE] = warn_in.life_short;
        raw[W_SCL_ERR] = warn_in.scale_alarm;
    end

    // Mask lookup and enabled detections
    generate
        for (genvar i = 0; i < NUM_WARN; i++)
        begin : g_mask
            // [R12] Mask bit positions
            assign masked[i] = warning_mask[MASK_POS[i]];
            // [R11] Masked warnings suppressed
            assign det[i] = raw[i] & ~masked[i];
            // [R10] Battery and lifetime fixed
            assign no_limit[i] = (i == W_BATTERY) || (i == W_LIFE)
                                 || (warning_hold_time == HOLD_NO_LIMIT);
        end
    endgenerate

    // =========================================
    // Next state
    always_comb
    begin
        state_d = state_q;

        // Motion flags, one cycle behind their conditions
        // [R01] Positioning done, both variants
        state_d.flags.positioning_done = motion.positioning_complete;
        state_d.flags.positioning_done_second = motion.positioning_complete_second;
        // [R02] Torque clamp flag
        state_d.flags.torque_clamped_flag = motion.torque_at_limit;
        // [R03] Zero speed flag
        state_d.flags.zero_speed_flag = motion.speed_is_zero;
        // [R04] Speed match flag
        state_d.flags.speed_match_flag = motion.speed_coincident;
        // [R22] Speed arrival compare
        state_d.flags.speed_arrival_flag = motion.motor_speed >= motion.arrival_speed;
        // [R17] Position command flag
        state_d.flags.position_cmd_flag = motion.position_cmd_active;
        // [R18] Speed limited flag
        state_d.flags.speed_limited_flag = motion.speed_limit_active;
        // [R19] Clearable alarm flag
        state_d.flags.clearable_alarm_flag = motion.alarm_clearable;
        // [R20] Speed command gating
        state_d.flags.speed_cmd_flag = motion.speed_cmd_active & motion.speed_control_mode;

        // One-second tick for the hold timers
        state_d.tick = 1'b0;
        if (state_q.sec_cnt >= SEC_LAST)
        begin
            state_d.sec_cnt = CNT_RST;
            state_d.tick = 1'b1;
        end
        else
        begin
            state_d.sec_cnt = state_q.sec_cnt + 32'h1;
        end

        // [R16] Energy-saving fan stop ignored
        if (warn_in.fan_stopped && !warn_in.fan_saving_stop)
        begin
            // Saturate at the one-second limit
            if (state_q.fan_cnt < FAN_LIMIT)
            begin
                state_d.fan_cnt = state_q.fan_cnt + 32'h1;
            end
        end
        else
        begin
            state_d.fan_cnt = CNT_RST;
        end

        // [R15] Encoder consecutive error count
        if (warn_in.enc_comm_err)
        begin
            // Error wins over a good frame in the same cycle
            if (state_q.enc_err != 8'hff)
            begin
                state_d.enc_err = state_q.enc_err + 8'h1;
            end
        end
        else if (warn_in.enc_comm_ok)
        begin
            state_d.enc_err = ERR_RST;
        end

        // [R15] Scale consecutive error count
        if (warn_in.scale_comm_err)
        begin
            if (state_q.scl_err != 8'hff)
            begin
                state_d.scl_err = state_q.scl_err + 8'h1;
            end
        end
        else if (warn_in.scale_comm_ok)
        begin
            state_d.scl_err = ERR_RST;
        end

        // Latch and hold each warning on its own
        for (int i = 0; i < NUM_WARN; i++)
        begin
            // [R23] Independent per-source latch
            if (masked[i])
            begin
                // Masked source drops its latch
                state_d.latch[i] = 1'b0;
                state_d.hold[i] = 4'h0;
            end
            else if (det[i])
            begin
                // Active source sets latch and reloads timer
                state_d.latch[i] = 1'b1;
                state_d.hold[i] = warning_hold_time;
            end
            else if (state_q.latch[i] && warning_clear)
            begin
                // Software clear, only when source is gone
                state_d.latch[i] = 1'b0;
                state_d.hold[i] = 4'h0;
            end
            // [R09] Timed hold expiry
            else if (state_q.latch[i] && !no_limit[i] && state_q.tick)
            begin
                if (state_q.hold[i] <= 4'h1)
                begin
                    state_d.latch[i] = 1'b0;
                    state_d.hold[i] = 4'h0;
                end
                else
                begin
                    state_d.hold[i] = state_q.hold[i] - 4'h1;
                end
            end
        end
    end

    // =========================================
    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // =========================================
    // Outputs
    assign flags = state_q.flags;
    assign warning_latched = state_q.latch;
    // [R05] Selector routing, code 0 ORs all, 1..10 single
    assign warning_out_a = route_warn(warning_select_a, state_q.latch);
    assign warning_out_b = route_warn(warning_select_b, state_q.latch);
    // Default assignments of the two fixed status pins
    assign status_output_five = state_q.flags.zero_speed_flag;
    assign status_output_six = state_q.flags.torque_clamped_flag;

    // =========================================
    // Assertions

    // Helper: cycles the fan has been stopped outside energy saving
    logic [31:0] fan_seen_q;
    always_ff @(posedge clk)
    begin
        if (rst || !warn_in.fan_stopped || warn_in.fan_saving_stop)
        begin
            fan_seen_q <= CNT_RST;
        end
        else if (fan_seen_q < FAN_LIMIT + 32'h1)
        begin
            fan_seen_q <= fan_seen_q + 32'h1;
        end
    end

    // [R06] OR of all warnings
    sel_all_or_a: assert property (@(posedge clk) disable iff (rst) // [R06]
        (warning_select_a == SEL_ALL) |-> (warning_out_a == |state_q.latch))
        else $error("Output a is not the OR of all warnings");

    // [R07] Single-warning routing
    sel_single_b_a: assert property (@(posedge clk) disable iff (rst) // [R07]
        (warning_select_b >= 4'h1 && warning_select_b <= SEL_MAX)
        |-> (warning_out_b == state_q.latch[warning_select_b - 4'h1]))
        else $error("Output b does not follow selected warning");

    // [R21] Battery route code three
    battery_route_a: assert property (@(posedge clk) disable iff (rst) // [R21]
        (warning_select_a == 4'h3 && !warning_mask[0] && warn_in.battery_low)
        ##1 (warning_select_a == 4'h3) |-> warning_out_a)
        else $error("Battery warning not routed on code three");

    // [R13] Overload threshold
    overload_raise_a: assert property (@(posedge clk) disable iff (rst) // [R13]
        (!warning_mask[7] && warn_in.load_factor >= LOAD_WARN_PCT)
        |=> state_q.latch[W_OVERLOAD])
        else $error("Overload warning not raised at threshold");

    // [R11] Masking suppresses detection
    mask_suppress_a: assert property (@(posedge clk) disable iff (rst) // [R11]
        warning_mask[5] |=> !state_q.latch[W_REGEN])
        else $error("Masked regeneration warning still latched");

    // [R10] Battery latch never times out
    battery_hold_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        (state_q.latch[W_BATTERY] && !warning_clear && !warning_mask[0])
        |=> state_q.latch[W_BATTERY])
        else $error("Battery warning dropped without clear");

    // [R14] Fan warning after one second
    fan_raise_a: assert property (@(posedge clk) disable iff (rst) // [R14]
        (fan_seen_q == FAN_LIMIT + 32'h1 && !warning_mask[6] && !$past(warning_mask[6]))
        |-> state_q.latch[W_FAN])
        else $error("Fan warning missing after stop time");

    // [R16] Energy-saving stop never warns
    fan_saving_a: assert property (@(posedge clk) disable iff (rst) // [R16]
        warn_in.fan_saving_stop |=> (state_q.fan_cnt == CNT_RST))
        else $error("Fan timer runs during energy saving");

    // [R20] Speed command flag gating
    speed_cmd_a: assert property (@(posedge clk) disable iff (rst) // [R20]
        ##1 (flags.speed_cmd_flag == ($past(motion.speed_cmd_active)
                                     && $past(motion.speed_control_mode))))
        else $error("Speed command flag wrong");

    // [R22] Speed arrival compare
    arrival_flag_a: assert property (@(posedge clk) disable iff (rst) // [R22]
        (motion.motor_speed >= motion.arrival_speed) |=> flags.speed_arrival_flag)
        else $error("Speed arrival flag missing");

    // [R02] Torque clamp tracks into pin six
    torque_pin_a: assert property (@(posedge clk) disable iff (rst) // [R02]
        motion.torque_at_limit ##1 1'b1 |-> (status_output_six && flags.torque_clamped_flag))
        else $error("Torque clamp flag or pin six missing");

    // [R15] Encoder error count over limit
    enc_comm_a: assert property (@(posedge clk) disable iff (rst) // [R15]
        (state_q.enc_err > warn_in.enc_err_limit && !warning_mask[4])
        |=> state_q.latch[W_ENC_COMM])
        else $error("Encoder communication warning not raised");

    // [R15] Scale error count over limit
    scale_comm_a: assert property (@(posedge clk) disable iff (rst) // [R15]
        (state_q.scl_err > warn_in.scale_err_limit && !warning_mask[10])
        |=> state_q.latch[W_SCL_COMM])
        else $error("Scale communication warning not raised");

    // [R10] Lifetime latch never times out
    life_hold_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        (state_q.latch[W_LIFE] && !warning_clear && !warning_mask[2])
        |=> state_q.latch[W_LIFE])
        else $error("Lifetime warning dropped without clear");

    // [R09] Timed latch only drops on a tick
    hold_tick_a: assert property (@(posedge clk) disable iff (rst) // [R09]
        (state_q.latch[W_OVERLOAD] && !state_q.tick && !warning_clear
         && !warning_mask[7])
        |=> state_q.latch[W_OVERLOAD])
        else $error("Overload warning dropped between ticks");

    // [R03] Zero speed tracks into pin five
    zero_pin_a: assert property (@(posedge clk) disable iff (rst) // [R03]
        motion.speed_is_zero |=> (status_output_five && flags.zero_speed_flag))
        else $error("Zero speed flag or pin five missing");

    // [R01] Both positioning flags follow completion
    pos_done_a: assert property (@(posedge clk) disable iff (rst) // [R01]
        (motion.positioning_complete && motion.positioning_complete_second)
        |=> (flags.positioning_done && flags.positioning_done_second))
        else $error("Positioning done flags missing");

endmodule

// ===== bench/ssw_host_cfg.sv
`timescale 1ns/1ps
// =========================================
// Host side: software writes the warning setup
module ssw_host_cfg (
    input wire logic clk,
    input wire logic [3:0] req_sel_a,
    input wire logic [3:0] req_sel_b,
    input wire logic [3:0] req_hold,
    input wire logic [10:0] req_mask,
    output logic [3:0] sel_a = 4'h0,
    output logic [3:0] sel_b = 4'h0,
    output logic [3:0] hold = 4'h0,
    output logic [10:0] mask = 11'h000
);
    // Pending setup, taken on the rising edge so bench writes never race it
    logic [3:0] pend_a = 4'h0;
    logic [3:0] pend_b = 4'h0;
    logic [3:0] pend_hold = 4'h0;
    logic [10:0] pend_mask = 11'h000;

    // Software writes are taken on the rising edge
    always @(posedge clk)
    begin
        // Selector codes above ten are never written
        if (req_sel_a <= 4'ha)
            pend_a <= req_sel_a;
        // Same guard for the second selector
        if (req_sel_b <= 4'ha)
            pend_b <= req_sel_b;
        // Latching time only takes defined settings
        if (req_hold <= 4'ha)
            pend_hold <= req_hold;
        pend_mask <= req_mask;
    end

    // Setup changes land on the falling edge, away from sampling
    always @(negedge clk)
    begin
        sel_a <= pend_a;
        sel_b <= pend_b;
        hold <= pend_hold;
        mask <= pend_mask;
    end
endmodule

// ===== bench/ssw_status_tb.sv
`timescale 1ns/1ps
// =========================================
// Self-checking bench for the status and warning outputs
module ssw_status_tb;
    import ssw_pkg::*;
    localparam int SEC = 20;
    localparam int FAN = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ssw_motion_t motion = '0;
    ssw_warn_in_t warn_in = '0;
    logic warning_clear = 1'b0;
    logic [3:0] sa = 4'h0;
    logic [3:0] sb = 4'h0;
    logic [3:0] hold = 4'h0;
    logic [10:0] mask = 11'h000;
    logic [3:0] sel_a_w;
    logic [3:0] sel_b_w;
    logic [3:0] hold_w;
    logic [10:0] mask_w;
    ssw_flags_t flags;
    logic [9:0] warning_latched;
    logic warning_out_a;
    logic warning_out_b;
    logic status_output_five;
    logic status_output_six;
    int error_cnt = 0;
    int n_tests = 0;
    logic [23:0] note_q[$];
    event ev;
    // Expected flags and latch vector
    ssw_flags_t fe = '0;
    logic [9:0] le = '0;
    // Mask bit of each warning, by selector code minus one
    int mpos[10] = '{7, 5, 0, 6, 4, 3, 9, 2, 8, 10};

    ssw_status #(.SEC_CYCLES(SEC), .FAN_CYCLES(FAN)) u_ssw_status (
        .clk(clk), .rst(rst), .motion(motion), .warn_in(warn_in),
        .warning_select_a(sel_a_w), .warning_select_b(sel_b_w),
        .warning_hold_time(hold_w), .warning_mask(mask_w),
        .warning_clear(warning_clear), .flags(flags),
        .warning_latched(warning_latched), .warning_out_a(warning_out_a),
        .warning_out_b(warning_out_b), .status_output_five(status_output_five),
        .status_output_six(status_output_six));

    ssw_host_cfg u_ssw_host_cfg (
        .clk(clk), .req_sel_a(sa), .req_sel_b(sb), .req_hold(hold),
        .req_mask(mask), .sel_a(sel_a_w), .sel_b(sel_b_w), .hold(hold_w),
        .mask(mask_w));

    // Clock, 50 ns period
    initial
    begin
        forever #25 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(logic [23:0] got, logic [23:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Expected level of a warning output for a selector code
    function automatic logic sel_out(logic [3:0] s);
        return (s == 4'h0) ? |le : (s <= 4'ha) ? le[s - 4'h1] : 1'b0;
    endfunction

    // Record the expected outputs, then let the watcher sample
    task automatic note();
        note_q.push_back({fe, le, sel_out(sa), sel_out(sb),
                          fe.zero_speed_flag, fe.torque_clamped_flag});
        #1;
        -> ev;
        #1;
    endtask

    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask

    // One-frame error or ok pulse on a link counter
    task automatic err(int i, logic e);
        if (i == 4)
            {warn_in.enc_comm_err, warn_in.enc_comm_ok} = {e, !e};
        else
            {warn_in.scale_comm_err, warn_in.scale_comm_ok} = {e, !e};
        cyc(1);
        {warn_in.enc_comm_err, warn_in.enc_comm_ok} = 2'b00;
        {warn_in.scale_comm_err, warn_in.scale_comm_ok} = 2'b00;
        cyc(1);
    endtask

    // Turn one warning source on or off
    task automatic src(int i, logic on);
        case (i)
            0: warn_in.load_factor = on ? 8'h55 : 8'h54;
            1: warn_in.regen_factor = on ? 8'h55 : 8'h54;
            2: warn_in.battery_low = on;
            3: warn_in.fan_stopped = on;
            5: warn_in.enc_overheat = on;
            6: warn_in.oscillation = on;
            7: warn_in.life_short = on;
            8: warn_in.scale_alarm = on;
            default: err(i, on);
        endcase
    endtask

    task automatic clr();
        warning_clear = 1'b1;
        cyc(1);
        warning_clear = 1'b0;
        cyc(1);
    endtask

    // Watcher: compares each result with the oldest note
    initial
    begin
        forever
        begin
            @(ev);
            check({flags, warning_latched, warning_out_a, warning_out_b,
                   status_output_five, status_output_six}, note_q.pop_front());
        end
    end

    // Watchdog against a hung run
    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        void'($urandom(51821));
        cyc(12);
        rst = 1'b0;
        // Idle speeds are equal, so arrival holds
        fe.speed_arrival_flag = 1'b1;
        cyc(1);
        note();
        // Random condition inputs against the flags
        for (int k = 0; k < 60; k++)
        begin
            motion = ssw_motion_t'(42'({$urandom, $urandom}));
            motion.motor_speed[15:2] = '0;
            motion.arrival_speed[15:2] = '0;
            fe = ssw_flags_t'({motion.positioning_complete,
                motion.positioning_complete_second, motion.torque_at_limit,
                motion.speed_is_zero, motion.speed_coincident,
                motion.motor_speed >= motion.arrival_speed,
                motion.position_cmd_active, motion.speed_limit_active,
                motion.alarm_clearable,
                motion.speed_cmd_active & motion.speed_control_mode});
            cyc(1);
            note();
        end
        motion = '0;
        fe = '0;
        fe.speed_arrival_flag = 1'b1;
        cyc(1);
        $display("test flags done");
        // Each warning: routing, masking, clearing
        for (int i = 0; i < 10; i++)
        begin
            src(i, 1'b1);
            cyc(i == 3 ? FAN + 3 : 3);
            le = 10'h001 << i;
            for (int s = 0; s <= 10; s++)
            begin
                sa = 4'(s);
                sb = 4'(10 - s);
                cyc(1);
                note();
            end
            mask = 11'h001 << mpos[i];
            cyc(2);
            le = '0;
            note();
            mask = 11'h000;
            src(i, 1'b0);
            cyc(3);
            clr();
            note();
        end
        $display("test routing done");
        // Timed hold against no-limit warnings
        hold = 4'h2;
        sa = 4'h0;
        src(0, 1'b1);
        src(2, 1'b1);
        src(7, 1'b1);
        cyc(3);
        le = 10'h085;
        src(0, 1'b0);
        src(2, 1'b0);
        src(7, 1'b0);
        cyc(15);
        note();
        cyc(30);
        le = 10'h084;
        note();
        clr();
        le = '0;
        note();
        hold = 4'h0;
        src(0, 1'b1);
        cyc(3);
        clr();
        le = 10'h001;
        note();
        src(0, 1'b0);
        cyc(3 * SEC);
        note();
        clr();
        le = '0;
        note();
        $display("test hold done");
        // Fan stopped on purpose for energy saving
        warn_in.fan_saving_stop = 1'b1;
        warn_in.fan_stopped = 1'b1;
        cyc(FAN + 5);
        note();
        warn_in.fan_stopped = 1'b0;
        warn_in.fan_saving_stop = 1'b0;
        $display("test fan saving done");
        // Link error count must exceed the limit
        warn_in.enc_err_limit = 8'h02;
        warn_in.scale_err_limit = 8'h02;
        for (int i = 4; i <= 9; i += 5)
        begin
            err(i, 1'b1);
            err(i, 1'b0);
            err(i, 1'b1);
            err(i, 1'b1);
            cyc(2);
            note();
            err(i, 1'b1);
            cyc(2);
            le = 10'h001 << i;
            note();
            err(i, 1'b0);
            clr();
            le = '0;
            note();
        end
        $display("test link errors done");
        print_verdict();
    end
endmodule
